// ---- tw_cfg_regs.vh ----
// constants of the three-wire serial configuration port
`ifndef TW_CFG_REGS_VH
`define TW_CFG_REGS_VH

// register space
`define TW_NUM_REGS 32
`define TW_REG_AW 5
`define TW_LONG_AW 13
`define TW_ADDR_CTRL 5'h00
`define TW_ADDR_PWR 5'h01
`define TW_ADDR_DATA 5'h02
`define TW_ADDR_MEMDATA 5'h11

// reset values
`define TW_DEF_CTRL 8'h00
`define TW_DEF_PWR 8'h40
`define TW_DEF_DATA 8'h34
`define TW_DEF_MEMDATA 8'h34
`define TW_DEF_OTHER 8'h00

// control register fields
`define TW_CFG_LSB_FIRST 6
`define TW_CFG_SWRST 5
`define TW_CFG_LONG 4

// instruction word layout, short (8 bit) and long (16 bit)
`define TW_SINS_RW 7
`define TW_SINS_CNT_HI 6
`define TW_SINS_CNT_LO 5
`define TW_SINS_ADDR_HI 4
`define TW_LINS_RW 15
`define TW_LINS_CNT_HI 14
`define TW_LINS_CNT_LO 13
`define TW_LINS_ADDR_HI 12
`define TW_SINS_LAST 4'h7
`define TW_LINS_LAST 4'hf
`define TW_BYTE_LAST 3'h7

// synchroniser reset levels {strap, data, select, clock}: the pins' idle
// levels, so no false select edge appears as reset is released
`define TW_PIN_IDLE 4'h2

`endif

// ---- tw_sync.v ----
// two-flop synchroniser for the port pins
`timescale 1ns/100ps
`default_nettype none
`include "tw_cfg_regs.vh"
module tw_sync (
    input wire clock,
    input wire rst_n,
    input wire [3:0] async_in,
    output wire [3:0] sync_out
);
    reg [3:0] meta_ff;
    reg [3:0] sync_ff;

    always @(posedge clock) begin
        if (!rst_n) begin
            meta_ff <= `TW_PIN_IDLE;
            sync_ff <= `TW_PIN_IDLE;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// ---- tw_regfile.v ----
// configuration register storage with default reload
`timescale 1ns/100ps
`default_nettype none
`include "tw_cfg_regs.vh"
module tw_regfile (
    input wire clock,
    input wire rst_n,
    input wire hold_all,
    input wire hold_rest,
    input wire wr_en,
    input wire [4:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [4:0] rd_addr,
    output wire [7:0] rd_data,
    output wire [255:0] regs_flat
);
    genvar i;
    generate
        for (i = 0; i < `TW_NUM_REGS; i = i + 1) begin : g_reg
            localparam [7:0] DEF =
                (i == `TW_ADDR_PWR) ? `TW_DEF_PWR :
                (i == `TW_ADDR_DATA) ? `TW_DEF_DATA :
                (i == `TW_ADDR_MEMDATA) ? `TW_DEF_MEMDATA :
                (i == `TW_ADDR_CTRL) ? `TW_DEF_CTRL : `TW_DEF_OTHER;
            // the control register is spared by the soft reset
            wire hold = hold_all | ((i != `TW_ADDR_CTRL) & hold_rest);
            reg [7:0] val_ff;
            always @(posedge clock) begin
                if (!rst_n || hold) begin
                    val_ff <= DEF;
                end else if (wr_en && wr_addr == i) begin
                    val_ff <= wr_data;
                end
            end
            assign regs_flat[i*8 +: 8] = val_ff;
        end
    endgenerate

    assign rd_data = regs_flat[rd_addr*8 +: 8];
endmodule
`default_nettype wire

// ---- tw_serial_port.v ----
// serial configuration port sequencer, top level
`timescale 1ns/100ps
`default_nettype none
`include "tw_cfg_regs.vh"

// Overview of operation
// R1: each cycle opens with an instruction byte on eight rising clocks, or two bytes on sixteen when control bit four is set
// R2: instruction top bit high means read, low means write
// R3: instruction bits six and five give one to four data bytes
// R4: low five instruction bits give the first register address
// R5: strap pin high then low restarts the sequencer, discarding partial data
// R6: each register is written as its last data bit arrives
// R7: master keeps the serial clock at or below 20 MHz
// R8: instruction and write bits are sampled on rising serial clock
// R9: read bits change on falling serial clock
// R10: chip select low gates a cycle; data pin released while high
// R11: master holds chip select low for the whole cycle
// R12: one two-way data pin carries both directions
// R13: control bit six picks bit order, msb first after reset
// R14: msb-first multibyte cycles decrement the address
// R15: lsb-first multibyte cycles increment the address
// R16: new port settings apply right after their last bit
// R17: soft reset bit reloads every register except register zero
// R18: master should change port settings only in single-byte cycles
// R19: strap high turns the port pins into mode controls
// R20: in pin mode the registers sit at their defaults
// R21: control bit four selects five or thirteen bit addresses
// R22: master clears the soft reset bit in a later cycle
// R23: chip select rising aborts the cycle, partial byte dropped
// R24: after the last byte further clocks are ignored until reselected
module tw_serial_port (
    input wire clock,
    input wire rst_n,
    input wire sclk,
    input wire cs_n,
    input wire sdio_in,
    output wire sdio_out,
    output wire sdio_oe_n,
    input wire port_reset_or_strap_pin,
    output wire [255:0] regs_flat,
    output wire bit_order_select,
    output wire long_instruction_select,
    output wire soft_reset_active,
    output wire pin_mode_active,
    output wire clock_mode_control_pin,
    output wire data_format_select,
    output wire pin_power_down
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_INSTR = 4'b0010;
    localparam [3:0] ST_DATA = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    wire [3:0] pins_s;
    wire sclk_s;
    wire cs_n_s;
    wire sdio_s;
    wire strap_s;
    reg sclk_d_ff;
    reg cs_n_d_ff;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_rise;

    tw_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({port_reset_or_strap_pin, sdio_in, cs_n, sclk}),
        .sync_out(pins_s)
    );

    assign sclk_s = pins_s[0];
    assign cs_n_s = pins_s[1];
    assign sdio_s = pins_s[2];
    assign strap_s = pins_s[3];

    always @(posedge clock) begin
        if (!rst_n) begin
            sclk_d_ff <= 1'b0;
            cs_n_d_ff <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            cs_n_d_ff <= cs_n_s;
        end
    end

    // R8: rising serial clock samples
    assign sclk_rise = sclk_s & ~sclk_d_ff;
    // R9: falling serial clock shifts out
    assign sclk_fall = ~sclk_s & sclk_d_ff;
    assign cs_rise = cs_n_s & ~cs_n_d_ff;

    ////////////////////////////////////////////////////////////////////
    // sequencer state

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [3:0] ins_cnt_ff;
    reg [3:0] nxt_ins_cnt;
    reg [15:0] ins_sh_ff;
    reg [15:0] nxt_ins_sh;
    reg [2:0] bit_cnt_ff;
    reg [2:0] nxt_bit_cnt;
    reg [7:0] dat_sh_ff;
    reg [7:0] nxt_dat_sh;
    reg [1:0] byte_cnt_ff;
    reg [1:0] nxt_byte_cnt;
    reg [1:0] nbytes_ff;
    reg [1:0] nxt_nbytes;
    reg read_ff;
    reg nxt_read;
    reg [12:0] addr_ff;
    reg [12:0] nxt_addr;
    reg wr_en;
    reg sdio_out_ff;

    wire [7:0] ctrl_reg;
    wire [7:0] rd_raw;
    wire [7:0] rd_data;
    wire lsb_first;
    wire long_ins;
    wire swrst;
    wire addr_ok;
    wire [3:0] ins_last;
    wire [3:0] ins_idx;
    wire [2:0] dat_idx;
    reg [15:0] ins_word;
    reg [7:0] dat_word;

    assign ctrl_reg = regs_flat[7:0];
    // R13: bit order from the live control register
    assign lsb_first = ctrl_reg[`TW_CFG_LSB_FIRST];
    // R21: address width select
    assign long_ins = ctrl_reg[`TW_CFG_LONG];
    assign swrst = ctrl_reg[`TW_CFG_SWRST];

    // R16: settings read straight from storage, so they act at once
    assign ins_last = long_ins ? `TW_LINS_LAST : `TW_SINS_LAST;
    assign ins_idx = lsb_first ? ins_cnt_ff : (ins_last - ins_cnt_ff);
    assign dat_idx = lsb_first ? bit_cnt_ff : (`TW_BYTE_LAST - bit_cnt_ff);

    // long addresses beyond the populated space read zero, ignore writes
    assign addr_ok = (addr_ff[12:`TW_REG_AW] == 8'h00);
    assign rd_data = addr_ok ? rd_raw : 8'h00;

    always @* begin
        ins_word = ins_sh_ff;
        ins_word[ins_idx] = sdio_s;
        dat_word = dat_sh_ff;
        dat_word[dat_idx] = sdio_s;
    end

    always @* begin
        nxt_state = state_ff;
        nxt_ins_cnt = ins_cnt_ff;
        nxt_ins_sh = ins_sh_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_dat_sh = dat_sh_ff;
        nxt_byte_cnt = byte_cnt_ff;
        nxt_nbytes = nbytes_ff;
        nxt_read = read_ff;
        nxt_addr = addr_ff;
        wr_en = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                // R10: chip select low opens a cycle
                if (!cs_n_s) begin
                    nxt_state = ST_INSTR;
                    nxt_ins_cnt = 4'h0;
                    nxt_ins_sh = 16'h0000;
                end
            end
            ST_INSTR: begin
                // R1: instruction shifts in over the first rising clocks
                if (sclk_rise) begin
                    nxt_ins_sh = ins_word;
                    nxt_ins_cnt = ins_cnt_ff + 4'h1;
                    if (ins_cnt_ff == ins_last) begin
                        nxt_state = ST_DATA;
                        nxt_bit_cnt = 3'h0;
                        nxt_byte_cnt = 2'h0;
                        nxt_dat_sh = 8'h00;
                        if (long_ins) begin
                            nxt_read = ins_word[`TW_LINS_RW];
                            nxt_nbytes = ins_word[`TW_LINS_CNT_HI:
                                                  `TW_LINS_CNT_LO];
                            nxt_addr = ins_word[`TW_LINS_ADDR_HI:0];
                        end else begin
                            // R2: direction bit
                            nxt_read = ins_word[`TW_SINS_RW];
                            // R3: byte count minus one
                            nxt_nbytes = ins_word[`TW_SINS_CNT_HI:
                                                  `TW_SINS_CNT_LO];
                            // R4: start address
                            nxt_addr = {8'h00,
                                        ins_word[`TW_SINS_ADDR_HI:0]};
                        end
                    end
                end
            end
            ST_DATA: begin
                if (sclk_rise) begin
                    nxt_dat_sh = dat_word;
                    nxt_bit_cnt = bit_cnt_ff + 3'h1;
                    if (bit_cnt_ff == `TW_BYTE_LAST) begin
                        nxt_dat_sh = 8'h00;
                        // R6: write at the last bit of each byte
                        wr_en = ~read_ff & addr_ok;
                        if (byte_cnt_ff == nbytes_ff) begin
                            nxt_state = ST_DONE;
                        end else begin
                            nxt_byte_cnt = byte_cnt_ff + 2'h1;
                            // R14: msb first walks down
                            // R15: lsb first walks up
                            if (lsb_first) begin
                                nxt_addr = addr_ff + 13'h0001;
                            end else begin
                                nxt_addr = addr_ff - 13'h0001;
                            end
                        end
                    end
                end
            end
            ST_DONE: begin
                // R24: clocks ignored until chip select cycles
                nxt_state = ST_DONE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock) begin
        // R5: strap high holds the sequencer at the instruction start
        // R23: chip select rising abandons the cycle
        if (!rst_n || strap_s || cs_rise || cs_n_s) begin
            state_ff <= ST_IDLE;
            ins_cnt_ff <= 4'h0;
            ins_sh_ff <= 16'h0000;
            bit_cnt_ff <= 3'h0;
            dat_sh_ff <= 8'h00;
            byte_cnt_ff <= 2'h0;
            nbytes_ff <= 2'h0;
            read_ff <= 1'b0;
            addr_ff <= 13'h0000;
        end else begin
            state_ff <= nxt_state;
            ins_cnt_ff <= nxt_ins_cnt;
            ins_sh_ff <= nxt_ins_sh;
            bit_cnt_ff <= nxt_bit_cnt;
            dat_sh_ff <= nxt_dat_sh;
            byte_cnt_ff <= nxt_byte_cnt;
            nbytes_ff <= nxt_nbytes;
            read_ff <= nxt_read;
            addr_ff <= nxt_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data out

    // the first bit is ready after the falling edge that follows the
    // last instruction bit; the master must sample on the next rise
    always @(posedge clock) begin
        if (!rst_n) begin
            sdio_out_ff <= 1'b0;
        end else if (sclk_fall && state_ff == ST_DATA && read_ff) begin
            // R9: next read bit on the falling edge
            sdio_out_ff <= rd_data[dat_idx];
        end
    end

    assign sdio_out = sdio_out_ff;
    // R12: one pin, driven only during read data
    // R10: released whenever chip select is high
    assign sdio_oe_n = ~(state_ff == ST_DATA && read_ff && !cs_n_s &&
                         !strap_s);

    ////////////////////////////////////////////////////////////////////
    // register storage and pin mode

    tw_regfile u_regs (
        .clock(clock),
        .rst_n(rst_n),
        // R20: pin mode forces defaults everywhere
        .hold_all(strap_s),
        // R17: soft reset reloads all but the control register
        .hold_rest(swrst),
        .wr_en(wr_en),
        .wr_addr(addr_ff[`TW_REG_AW-1:0]),
        .wr_data(dat_word),
        .rd_addr(addr_ff[`TW_REG_AW-1:0]),
        .rd_data(rd_raw),
        .regs_flat(regs_flat)
    );

    assign bit_order_select = lsb_first;
    assign long_instruction_select = long_ins;
    assign soft_reset_active = swrst;

    // R19: strap high repurposes the port pins
    assign pin_mode_active = strap_s;
    assign clock_mode_control_pin = strap_s & sclk_s;
    assign data_format_select = strap_s & sdio_s;
    assign pin_power_down = strap_s & cs_n_s;
endmodule
`default_nettype wire

// ---- tw_port_properties.sv ----
// concurrent checks on the serial configuration port outputs
`timescale 1ns/100ps
`default_nettype none
`include "tw_cfg_regs.vh"
module tw_port_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    input wire logic port_reset_or_strap_pin,
    input wire logic [255:0] regs_flat,
    input wire logic bit_order_select,
    input wire logic long_instruction_select,
    input wire logic soft_reset_active,
    input wire logic pin_mode_active,
    input wire logic clock_mode_control_pin,
    input wire logic data_format_select,
    input wire logic pin_power_down
);
default clocking cb @(posedge clock); endclocking
default disable iff (!rst_n);
logic sclk_d_ff;
logic [3:0] fall_age_ff;
// age of the last serial falling edge, saturating
always @(posedge clock) begin
    sclk_d_ff <= sclk;
    if (!rst_n || (sclk_d_ff && !sclk))
        fall_age_ff <= {!rst_n, 3'h0};
    else if (fall_age_ff != 4'hf)
        fall_age_ff <= fall_age_ff + 4'h1;
end
a_oe_released: assert property ((cs_n || port_reset_or_strap_pin)[*6]
    |-> sdio_oe_n) else $error("data pin driven while deselected");
a_read_launch: assert property ($changed(sdio_out) && !sdio_oe_n
    |-> fall_age_ff <= 4'h7) else $error("read bit moved off a fall");
a_pin_outs_off: assert property (!pin_mode_active
    |-> !(clock_mode_control_pin || data_format_select || pin_power_down))
    else $error("pin outputs active outside pin mode");
a_pin_mode_sync: assert property ($stable(port_reset_or_strap_pin)[*4]
    |-> pin_mode_active == port_reset_or_strap_pin)
    else $error("pin mode does not follow strap");
a_pin_pass: assert property ((pin_mode_active && $stable(sclk)
    && $stable(cs_n) && $stable(sdio_in))[*4]
    |-> {clock_mode_control_pin, pin_power_down, data_format_select}
    == {sclk, cs_n, sdio_in}) else $error("pin mode controls wrong");
a_pin_defaults: assert property (pin_mode_active[*2]
    |-> regs_flat[23:0] == {`TW_DEF_DATA, `TW_DEF_PWR, `TW_DEF_CTRL})
    else $error("registers not at defaults in pin mode");
a_soft_reload: assert property (soft_reset_active[*2]
    |-> regs_flat[23:8] == {`TW_DEF_DATA, `TW_DEF_PWR})
    else $error("soft reset does not reload");
a_ctrl_fields: assert property ({bit_order_select, soft_reset_active,
    long_instruction_select} == regs_flat[6:4])
    else $error("control outputs differ from register zero");
a_regs_quiet: assert property ((cs_n && !port_reset_or_strap_pin
    && !soft_reset_active)[*6] |-> $stable(regs_flat))
    else $error("register changed while deselected");
c_soft: cover property (soft_reset_active);
c_pin: cover property (pin_mode_active);
c_read: cover property (!sdio_oe_n);
c_long: cover property (long_instruction_select);
endmodule
bind tw_serial_port tw_port_properties chk (.clock(clock), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .port_reset_or_strap_pin(port_reset_or_strap_pin),
    .regs_flat(regs_flat), .bit_order_select(bit_order_select),
    .long_instruction_select(long_instruction_select),
    .soft_reset_active(soft_reset_active), .pin_mode_active(pin_mode_active),
    .clock_mode_control_pin(clock_mode_control_pin),
    .data_format_select(data_format_select), .pin_power_down(pin_power_down));
`default_nettype wire

// ---- tw_host_model.sv ----
// serial master model on the far side of the configuration port
`timescale 1ns/100ps
`default_nettype none
module tw_host_model (
    input wire logic clock,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    output var logic sclk,
    output var logic cs_n,
    output wire logic sdio_in,
    output var logic strap
);
logic hbit;
initial {sclk, cs_n, hbit, strap} = 4'h4;
assign sdio_in = sdio_oe_n ? hbit : sdio_out;
task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
endtask
task automatic shift(input logic b, input logic drv, output logic r);
    sclk = 1'b0;
    hbit = drv ? b : ~hbit;
    wait_n(13);
    sclk = 1'b1;
    r = sdio_in;
    wait_n(12);
endtask
task automatic xfer(input logic [7:0] ins, input logic [31:0] wd,
    input int nbits, input logic lsb, input logic by_strap,
    output logic [31:0] rd);
    int i;
    int j;
    logic r;
    rd = 32'h0;
    cs_n = 1'b0;
    wait_n(6);
    for (i = 0; i < 8; i++)
        shift(ins[lsb ? i : 7 - i], 1'b1, r);
    for (i = 0; i < nbits; i++) begin
        j = (i & ~7) + (lsb ? i % 8 : 7 - i % 8);
        shift(wd[j], !ins[7], r);
        rd[j] = r;
    end
    sclk = 1'b0;
    wait_n(6);
    if (by_strap) begin
        strap = 1'b1;
        wait_n(6);
        strap = 1'b0;
        wait_n(6);
        // fresh instruction under the same select
        for (i = 0; i < 16; i++)
            shift(i < 8 ? ins[lsb ? i : 7 - i] : wd[lsb ? i - 8 : 15 - i],
                1'b1, r);
        sclk = 1'b0;
        wait_n(6);
    end
    cs_n = 1'b1;
    hbit = ~hbit;
    wait_n(8);
endtask
endmodule
`default_nettype wire

// ---- three_wire_serial_config_port_test.sv ----
// self-checking bench of the serial configuration port
`timescale 1ns/100ps
`default_nettype none
`include "tw_cfg_regs.vh"
module three_wire_serial_config_port_test;
logic clock = 1'b0;
logic rst_n = 1'b0;
wire logic sclk, cs_n, sdio_in, sdio_out, sdio_oe_n, strap;
wire logic order_sel, long_sel, soft_rst, pin_mode, clk_mode, fmt, pwr_dn;
wire logic [255:0] regs_flat;
logic [31:0] rd;
int n_mismatch = 0;
int samples_checked = 0;
always #2.5 clock = ~clock;
tw_serial_port uut (.clock(clock), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .port_reset_or_strap_pin(strap),
    .regs_flat(regs_flat), .bit_order_select(order_sel),
    .long_instruction_select(long_sel), .soft_reset_active(soft_rst),
    .pin_mode_active(pin_mode), .clock_mode_control_pin(clk_mode),
    .data_format_select(fmt), .pin_power_down(pwr_dn));
tw_host_model host (.clock(clock), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .strap(strap));
////////////////////////////////////////////////////////////////////////
task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
function automatic logic [7:0] reg_at(input int a);
    return regs_flat[a * 8 +: 8];
endfunction
task automatic wr(input logic [7:0] ins, input logic [31:0] wd,
    input int nbits, input logic lsb);
    host.xfer(ins, wd, nbits, lsb, 1'b0, rd);
endtask
task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
task automatic t_counts;
    int c;
    int k;
    logic [31:0] wd;
    for (c = 0; c < 4; c++) begin
        wd = 32'hd4c3b2a1 ^ {4{c[7:0]}};
        wr({1'b0, c[1:0], 5'h1c}, wd, (c + 1) * 8, 1'b0);
        for (k = 0; k <= c; k++)
            check(reg_at(28 - k), wd[k * 8 +: 8]);
        check(reg_at(27 - c), `TW_DEF_OTHER);
    end
endtask
task automatic t_read;
    host.xfer(8'hbc, 32'h0, 16, 1'b0, 1'b0, rd);
    check(rd[7:0], 8'ha2);
    check(rd[15:8], 8'hb1);
    check({7'h00, sdio_oe_n}, 8'h01);
endtask
task automatic t_lsb;
    wr(8'h00, 32'h40, 8, 1'b0);
    check({7'h00, order_sel}, 8'h01);
    wr(8'h26, 32'h5a3c, 16, 1'b1);
    check(reg_at(6), 8'h3c);
    check(reg_at(7), 8'h5a);
    host.xfer(8'h87, 32'h0, 8, 1'b1, 1'b0, rd);
    check(rd[7:0], 8'h5a);
    wr(8'h00, 32'h00, 8, 1'b1);
    check({7'h00, order_sel}, 8'h00);
endtask
task automatic t_soft;
    wr(8'h01, 32'ha5, 8, 1'b0);
    check(reg_at(1), 8'ha5);
    wr(8'h00, 32'h20, 8, 1'b0);
    check(reg_at(1), `TW_DEF_PWR);
    check(reg_at(0), 8'h20);
    check({7'h00, soft_rst}, 8'h01);
    wr(8'h00, 32'h00, 8, 1'b0);
    wr(8'h01, 32'h5a, 8, 1'b0);
    check(reg_at(1), 8'h5a);
endtask
task automatic t_abort;
    wr(8'h09, 32'hff, 5, 1'b0);
    check(reg_at(9), 8'h00);
    host.xfer(8'h09, 32'hff, 7, 1'b0, 1'b1, rd);
    check(reg_at(9), 8'hff);
    wr(8'h09, 32'h6699, 16, 1'b0);
    check(reg_at(9), 8'h99);
    check(reg_at(8), 8'h00);
endtask
// sixteen-bit instruction: high byte first, low byte sent as data
task automatic t_long;
    wr(8'h00, 32'h10, 8, 1'b0);
    check({7'h00, long_sel}, 8'h01);
    wr(8'h00, 32'hc70b, 16, 1'b0);
    check(reg_at(11), 8'hc7);
    wr(8'h00, 32'h5520, 16, 1'b0);
    check(reg_at(0), 8'h10);
    wr(8'h00, 32'h0000, 16, 1'b0);
    check({7'h00, long_sel}, 8'h00);
endtask
task automatic t_pin;
    host.strap = 1'b1;
    host.sclk = 1'b1;
    host.hbit = 1'b1;
    host.wait_n(8);
    check({4'h0, pin_mode, clk_mode, fmt, pwr_dn}, 8'h0f);
    check(reg_at(1), `TW_DEF_PWR);
    host.sclk = 1'b0;
    host.hbit = 1'b0;
    host.cs_n = 1'b0;
    host.wait_n(8);
    check({4'h0, pin_mode, clk_mode, fmt, pwr_dn}, 8'h08);
    host.cs_n = 1'b1;
    host.wait_n(8);
    host.strap = 1'b0;
    host.wait_n(8);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (6) @(negedge clock);
    check(reg_at(0), `TW_DEF_CTRL);
    check(reg_at(2), `TW_DEF_DATA);
    t_counts;
    t_read;
    t_lsb;
    t_long;
    t_soft;
    t_abort;
    t_pin;
    stop_test;
end
// hang guard
initial begin
    repeat (90000) @(posedge clock);
    n_mismatch++;
    stop_test;
end
endmodule
`default_nettype wire
